// >>> design/lvp_host_tx.sv
// Purpose: video source end, serialises pixels onto the link
// Assumes: supply and enable inputs come from outside this clock
// Notes:   link clock made here by dividing the system clock
//
// Behaviour
// - select high for VESA, low JEIDA
// - colour components are unsigned 8-bit levels
// - bit 7 most, bit 0 least significant
// - all zeros black, all ones white
// - logic one is high, zero low
// - framing comes only from data enable
// - pixel clock within 60 to 82 MHz; here the system clock divided by 28, one pixel per link period
// - link clock jitter at most 200 ps
// - spread spectrum within 2%, 200 kHz
// - frame rate within the two bands; here far below them, set by the scaled-down pixel clock
// - exactly 768 active lines per frame
// - horizontal blank 76 to 570 clocks
// - link inputs low while supply off
// - never drive before supply is up
// - drive all signals while supply on
// - backlight on after video, off before
// - unused slots held at fixed level
// - factory pins left unconnected
// - four data pairs plus clock pair
module lvp_host_tx
   import lvp_pkg::*;
#(
   parameter int H_ACT   = H_ACTIVE,   // Enabled clocks per line
   parameter int H_TOT   = H_TOTAL,    // Clocks per line
   parameter int V_ACT   = V_ACTIVE,   // Enabled lines per frame
   parameter int V_TOT   = V_TOTAL     // Lines per frame
)(
   input  wire logic               clk_i,
   input  wire logic               resetn_i,
   lvp_link_if.host                link,
   input  wire logic               supply_on_i,
   input  wire logic               video_en_i,
   input  wire logic               jeida_i,
   input  wire logic [COLOR_W-1:0] red_i,
   input  wire logic [COLOR_W-1:0] green_i,
   input  wire logic [COLOR_W-1:0] blue_i,
   output logic                    pix_ack_o,
   output logic                    backlight_on_o
);

   // Outside levels, two flip-flops each
   logic              sup_s1_q;
   logic              sup_s2_q;
   logic              ven_s1_q;
   logic              ven_s2_q;
   logic              jei_s1_q;
   logic              jei_s2_q;

   // Link timing
   logic [2:0]        cyc_q;      // Cycle within slot
   logic [2:0]        slot_q;     // Slot within link period
   logic              tick;       // Last cycle of a slot
   logic              load;       // Last cycle of a period
   logic [2:0]        next_slot;

   // Raster position and pixel word
   logic [X_W-1:0]    h_q;        // Pixel clock within line
   logic [Y_W-1:0]    v_q;        // Line within frame
   logic              de_next;    // Enable for the pixel being loaded
   logic              frame_top;  // Loading pixel 0 of line 0
   logic              run_now;    // Run state for the pixel being loaded
   logic [WORD_W-1:0] word_q;     // Word on the wire
   logic [WORD_W-1:0] new_word;   // Word for the next period
   logic [WORD_W-1:0] out_word;   // Word feeding the next slot

   // Link pin registers
   logic [LANES-1:0]  lane_q;
   logic              lclk_q;
   logic              sel_q;      // Mapping follows the pin while video is stopped
   logic              run_q;      // Video frames flowing
   logic              bl_q;

   // Synchronisers; only the second stage is read
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sup_s1_q <= 1'b0;
         sup_s2_q <= 1'b0;
         ven_s1_q <= 1'b0;
         ven_s2_q <= 1'b0;
         jei_s1_q <= 1'b0;
         jei_s2_q <= 1'b0;
      end
      else
      begin
         sup_s1_q <= supply_on_i;
         sup_s2_q <= sup_s1_q;
         ven_s1_q <= video_en_i;
         ven_s2_q <= ven_s1_q;
         jei_s1_q <= jeida_i;
         jei_s2_q <= jei_s1_q;
      end
   end

   assign tick      = (cyc_q == 3'(BIT_CYCLES - 1));
   assign load      = tick && (slot_q == 3'(SLOTS - 1));
   assign next_slot = (slot_q == 3'(SLOTS - 1)) ? '0 : slot_q + 1'b1;

   // Divider from the system clock: no modulation, no jitter beyond
   // the source oscillator
   // Rate scaled down from the pixel clock range, one clock only
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cyc_q  <= '0;
         slot_q <= 3'(SLOTS - 1);
      end
      else if (!sup_s2_q)
      begin
         // Held so the first period starts cleanly at supply-on
         cyc_q  <= '0;
         slot_q <= 3'(SLOTS - 1);
      end
      else
      begin
         cyc_q <= tick ? '0 : cyc_q + 1'b1;
         if (tick)
            slot_q <= next_slot;
      end
   end

   // Enabled window is exactly H_ACT by V_ACT
   // Start and stop take effect at the frame-top pixel itself, so no
   // short first or last line reaches the panel
   assign run_now   = frame_top ? ven_s2_q : run_q;
   assign de_next   = run_now && (h_q < X_W'(H_ACT)) && (v_q < Y_W'(V_ACT));
   assign frame_top = load && (h_q == '0) && (v_q == '0);

   // Raster counters; totals set blanking and frame rate
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         h_q <= '0;
         v_q <= '0;
      end
      else if (!sup_s2_q)
      begin
         h_q <= '0;
         v_q <= '0;
      end
      else if (load)
      begin
         if (h_q == X_W'(H_TOT - 1))
         begin
            h_q <= '0;
            v_q <= (v_q == Y_W'(V_TOT - 1)) ? '0 : v_q + 1'b1;
         end
         else
            h_q <= h_q + 1'b1;
      end
   end

   // Video starts and stops on frame boundaries, and stops at once when supply drops
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         run_q <= 1'b0;
      else if (!sup_s2_q)
         run_q <= 1'b0;
      else if (frame_top)
         run_q <= ven_s2_q;
   end

   // Backlight after one whole frame, dropped before video ends
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         bl_q <= 1'b0;
      else if (!sup_s2_q || !ven_s2_q)
         bl_q <= 1'b0;
      else if (frame_top && run_q)
         bl_q <= 1'b1;
   end

   // Colour zero in blanking, spare slot low
   always_comb
   begin
      new_word                         = '0;
      new_word[IDX_DE]                 = de_next;
      if (de_next)
      begin
         new_word[RED_LSB +: COLOR_W]   = red_i;   // Bit 7 weightiest
         new_word[GREEN_LSB +: COLOR_W] = green_i;
         new_word[BLUE_LSB +: COLOR_W]  = blue_i;
      end
      out_word = (next_slot == '0) ? new_word : word_q;
   end

   // Pixel word held for one link period
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         word_q <= '0;
      else if (!sup_s2_q)
         word_q <= '0;
      else if (load)
         word_q <= new_word;
   end

   // Consumed-pixel strobe for the user side
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         pix_ack_o <= 1'b0;
      else
         pix_ack_o <= sup_s2_q && load && de_next;
   end

   // Mapping follows the pin only while video is stopped, so the
   // first pixel of a run already uses it; static while running
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sel_q <= 1'b0;
      else if (!sup_s2_q)
         sel_q <= 1'b0;
      else if (!run_q)
         sel_q <= jei_s2_q ? !SEL_VESA : SEL_VESA;
   end

   // Serialiser: seven slots per pair, clock high in the first four
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         lane_q <= '0;
         lclk_q <= 1'b0;
      end
      else if (!sup_s2_q)
      begin
         // Supply off: every line low, nothing driven early
         lane_q <= '0;
         lclk_q <= 1'b0;
      end
      else if (tick)
      begin
         for (int l = 0; l < LANES; l++)
            lane_q[l] <= out_word[slot_src(sel_q, l, 32'(next_slot))];
         lclk_q <= (next_slot < 3'(CLK_HI));
      end
   end

   // Pins: pairs complemented only while powered, so all lines are
   // actively driven then and low otherwise
   // Factory positions have no pins here and stay open
   assign link.lane_pos       = lane_q;
   assign link.lane_neg       = sup_s2_q ? ~lane_q : '0;
   assign link.link_clock_pos = lclk_q;
   assign link.link_clock_neg = sup_s2_q ? ~lclk_q : 1'b0;
   assign link.bit_map_select = sel_q;
   assign backlight_on_o      = bl_q;

endmodule

// >>> design/lvp_pkg.sv
// Purpose: shared constants for the serial panel video link
// Assumes: one 20 MHz system clock on both ends
// Notes:   slot tables give the pixel-word bit carried per lane slot
package lvp_pkg;

   localparam int LANES      = 4;     // Data pairs on the link
   localparam int SLOTS      = 7;     // Bits per pair per link period
   localparam int COLOR_W    = 8;     // Bits per colour component
   localparam int WORD_W     = 26;    // Pixel word: colours, enable, spare
   localparam int IDX_W      = 5;     // Width of a pixel-word bit index
   localparam int RED_LSB    = 0;     // Red level bits 7..0
   localparam int GREEN_LSB  = 8;     // Green level bits 15..8
   localparam int BLUE_LSB   = 16;    // Blue level bits 23..16
   localparam int IDX_DE     = 24;    // Data enable position
   localparam int IDX_SPARE  = 25;    // Unused slot, always low
   localparam int X_W        = 11;    // Pixel index width
   localparam int Y_W        = 10;    // Line index width
   localparam int GAP_W      = 12;    // Blank run counter width

   // Video geometry in pixel clocks and line periods
   localparam int H_ACTIVE   = 1366;
   localparam int H_TOTAL    = 1560;
   localparam int H_BLANK_MN = 76;
   localparam int H_BLANK_MX = 570;
   localparam int V_ACTIVE   = 768;
   localparam int V_TOTAL    = 806;
   localparam int V_BLANK_MN = 10;
   localparam int V_BLANK_MX = 120;

   // Link timing in system clock cycles and slots; frame gap in pixel clocks
   localparam int BIT_CYCLES = 4;     // Cycles per serial slot
   localparam int CLK_HI     = 4;     // Slots with link clock high
   localparam int SAMPLE_PH  = BIT_CYCLES / 2 - 1; // Mid-slot sample
   localparam int FRAME_GAP  = H_TOTAL; // Blank run that opens a frame

   localparam logic SEL_VESA = 1'b1;  // Select level for VESA order

   // Slot source tables, index lane*SLOTS+slot
   localparam logic [IDX_W-1:0] VESA_MAP [LANES*SLOTS] = '{
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08,
      5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h11,
      5'h12, 5'h13, 5'h14, 5'h15, 5'h19, 5'h19, 5'h18,
      5'h06, 5'h07, 5'h0e, 5'h0f, 5'h16, 5'h17, 5'h19};
   localparam logic [IDX_W-1:0] JEIDA_MAP [LANES*SLOTS] = '{
      5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0a,
      5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h12, 5'h13,
      5'h14, 5'h15, 5'h16, 5'h17, 5'h19, 5'h19, 5'h18,
      5'h00, 5'h01, 5'h08, 5'h09, 5'h10, 5'h11, 5'h19};

   // Pixel-word bit carried by one lane slot
   function automatic logic [IDX_W-1:0] slot_src(input logic vesa,
                                                input int   lane,
                                                input int   slot);
      int i;
      i = lane * SLOTS + slot;
      return vesa ? VESA_MAP[i] : JEIDA_MAP[i];
   endfunction

endpackage

// >>> design/lvp_link_if.sv
// Purpose: pins between the video source and the panel input
// Assumes: all lines driven one way, source to panel
// Notes:   differential pairs kept as separate true and complement lines
interface lvp_link_if;
   logic [3:0] lane_pos;        // Data pairs, true side
   logic [3:0] lane_neg;        // Data pairs, complement side
   logic       link_clock_pos;  // Link clock, true side
   logic       link_clock_neg;  // Link clock, complement side
   logic       bit_map_select;  // High VESA, low JEIDA

   modport host  (output lane_pos, lane_neg, link_clock_pos,
                  link_clock_neg, bit_map_select);
   modport panel (input  lane_pos, lane_neg, link_clock_pos,
                  link_clock_neg, bit_map_select);
endinterface

// >>> design/lvp_frame_track.sv
// Purpose: line and frame framing from data enable alone
// Assumes: step_i pulses once per received pixel clock
// Notes:   all outputs registered, aligned with the pixel outputs
module lvp_frame_track
   import lvp_pkg::*;
#(
   parameter int ACTIVE_PIX   = H_ACTIVE,
   parameter int ACTIVE_LINES = V_ACTIVE,
   parameter int GAP_LIMIT    = FRAME_GAP
)(
   input  wire logic           clk_i,
   input  wire logic           resetn_i,
   input  wire logic           step_i,
   input  wire logic           de_i,
   output logic                frame_start_o,
   output logic                line_start_o,
   output logic [X_W-1:0]      x_o,
   output logic [Y_W-1:0]      y_o,
   output logic                line_err_o,
   output logic                frame_err_o
);

   logic             de_prev_q;  // Enable of previous pixel
   logic [GAP_W-1:0] gap_q;      // Run of blank pixels
   logic [X_W-1:0]   x_q;        // Pixel index in line
   logic [Y_W-1:0]   y_q;        // Line index in frame
   logic             seen_q;     // A frame start was found
   logic             new_line;
   logic             new_frame;

   assign new_line  = step_i && de_i && !de_prev_q;
   // A blank run longer than a line opens a frame
   assign new_frame = new_line && (gap_q > GAP_W'(GAP_LIMIT));

   // Counters advance only on received pixels
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         de_prev_q <= 1'b0;
         gap_q     <= '0;
         x_q       <= '0;
         y_q       <= '0;
         seen_q    <= 1'b0;
      end
      else if (step_i)
      begin
         de_prev_q <= de_i;
         if (de_i)
         begin
            gap_q <= '0;
            // First enabled clock is pixel zero
            x_q   <= new_line ? '0 : x_q + 1'b1;
            if (new_frame)
            begin
               y_q    <= '0;
               seen_q <= 1'b1;
            end
            else if (new_line)
               y_q <= y_q + 1'b1;
         end
         else if (gap_q != '1)
            gap_q <= gap_q + 1'b1; // Saturates, frame gap only needs a floor
      end
   end

   // Registered framing pulses and length checks
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         frame_start_o <= 1'b0;
         line_start_o  <= 1'b0;
         line_err_o    <= 1'b0;
         frame_err_o   <= 1'b0;
         x_o           <= '0;
         y_o           <= '0;
      end
      else
      begin
         frame_start_o <= new_frame;
         line_start_o  <= new_line;
         // Line ends with wrong active width
         line_err_o    <= step_i && !de_i && de_prev_q
                          && (x_q + 1'b1 != X_W'(ACTIVE_PIX));
         // Frame ends with wrong active line count
         frame_err_o   <= new_frame && seen_q
                          && (y_q + 1'b1 != Y_W'(ACTIVE_LINES));
         if (step_i && de_i)
         begin
            x_o <= new_line ? '0 : x_q + 1'b1;
            y_o <= new_frame ? '0 : (new_line ? y_q + 1'b1 : y_q);
         end
      end
   end

endmodule

// >>> design/lvp_panel_rx.sv
// Purpose: panel end, recovers pixels from the serial link
// Assumes: link period is SLOTS*BIT_CYCLES system cycles
// Notes:   link pins sampled through two flip-flops, edge found here
module lvp_panel_rx
   import lvp_pkg::*;
#(
   parameter int ACTIVE_PIX   = H_ACTIVE,
   parameter int ACTIVE_LINES = V_ACTIVE,
   parameter int GAP_LIMIT    = FRAME_GAP
)(
   input  wire logic               clk_i,
   input  wire logic               resetn_i,
   lvp_link_if.panel               link,
   output logic [COLOR_W-1:0]      red_o,
   output logic [COLOR_W-1:0]      green_o,
   output logic [COLOR_W-1:0]      blue_o,
   output logic                    pix_valid_o,
   output logic                    frame_start_o,
   output logic                    line_start_o,
   output logic [X_W-1:0]          pix_x_o,
   output logic [Y_W-1:0]          line_y_o,
   output logic                    line_len_err_o,
   output logic                    frame_len_err_o
);

   logic [5:0]        s1_q;       // First sync stage: select, clock, lanes
   logic [5:0]        s2_q;       // Second sync stage
   logic              ck_prev_q;  // Previous synced link clock
   logic              rise;
   logic [2:0]        bc_q;       // Cycle within slot
   logic [2:0]        sl_q;       // Slot, 7 means idle
   logic              armed_q;    // A link clock edge was seen
   logic              sample;
   logic [SLOTS-1:0]  raw_q [LANES]; // Bits of the current period
   logic              done_q;     // Full period captured
   logic [WORD_W-1:0] word;

   // Two-stage sampling of the true-side link lines and the select
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= {link.bit_map_select, link.link_clock_pos, link.lane_pos};
         s2_q <= s1_q;
      end
   end

   assign rise   = s2_q[4] && !ck_prev_q;
   assign sample = armed_q && (sl_q < 3'(SLOTS)) && (bc_q == 3'(SAMPLE_PH));

   // Slot timing restarts on every link clock rise
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ck_prev_q <= 1'b0;
         bc_q      <= '0;
         sl_q      <= 3'(SLOTS);
         armed_q   <= 1'b0;
      end
      else
      begin
         ck_prev_q <= s2_q[4];
         if (rise)
         begin
            bc_q    <= '0;
            sl_q    <= '0;
            armed_q <= 1'b1;
         end
         else if (bc_q == 3'(BIT_CYCLES - 1))
         begin
            bc_q <= '0;
            if (sl_q < 3'(SLOTS))
               sl_q <= sl_q + 1'b1;
         end
         else
            bc_q <= bc_q + 1'b1;
      end
   end

   // Seven bits per pair per period, kept by slot
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (int l = 0; l < LANES; l++)
            raw_q[l] <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         if (sample)
            for (int l = 0; l < LANES; l++)
               raw_q[l][sl_q] <= s2_q[l]; // High level is logic one
         done_q <= sample && (sl_q == 3'(SLOTS - 1));
      end
   end

   // Slot order follows the selected mapping
   always_comb
   begin
      word = '0;
      for (int l = 0; l < LANES; l++)
         for (int k = 0; k < SLOTS; k++)
            word[slot_src(s2_q[5], l, k)] = raw_q[l][k];
   end

   // Colour captured only in enabled periods
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         red_o       <= '0;
         green_o     <= '0;
         blue_o      <= '0;
         pix_valid_o <= 1'b0;
      end
      else
      begin
         pix_valid_o <= done_q && word[IDX_DE];
         if (done_q && word[IDX_DE])
         begin
            // Unsigned levels, larger is brighter
            red_o   <= word[RED_LSB +: COLOR_W];
            green_o <= word[GREEN_LSB +: COLOR_W];
            blue_o  <= word[BLUE_LSB +: COLOR_W];
         end
      end
   end

   // Framing from data enable alone
   lvp_frame_track #(
      .ACTIVE_PIX   (ACTIVE_PIX),
      .ACTIVE_LINES (ACTIVE_LINES),
      .GAP_LIMIT    (GAP_LIMIT)
   ) u_track (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .step_i        (done_q),
      .de_i          (word[IDX_DE]),
      .frame_start_o (frame_start_o),
      .line_start_o  (line_start_o),
      .x_o           (pix_x_o),
      .y_o           (line_y_o),
      .line_err_o    (line_len_err_o),
      .frame_err_o   (frame_len_err_o)
   );

endmodule

// >>> bench/lvp_link_chk.sv
// Purpose: timing checks on the serial link between both ends
// Assumes: one system clock, link period of 28 cycles
// Notes:   slot figures follow from the host divider of 4 cycles
module lvp_link_chk (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [3:0] lane_pos,
   input  wire logic [3:0] lane_neg,
   input  wire logic       link_clock_pos,
   input  wire logic       link_clock_neg,
   input  wire logic       bit_map_select
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // Pairs mirror each other, or the complement lines rest low with supply off
   lane_pair_a: assert property (lane_neg == ~lane_pos || lane_neg == 4'h0)
      else $error("lane complement wrong");
   clk_pair_a: assert property (link_clock_neg != link_clock_pos || !link_clock_neg)
      else $error("clock complement wrong");
   // High for slots 0..3, low for slots 4..6
   clk_high_a: assert property ($rose(link_clock_pos) |-> ##16 $fell(link_clock_pos))
      else $error("clock high phase wrong");
   clk_low_a: assert property ($fell(link_clock_pos) |-> ##12 $rose(link_clock_pos))
      else $error("clock low phase wrong");
   clk_period_a: assert property ($rose(link_clock_pos) |-> ##28 $rose(link_clock_pos))
      else $error("link period wrong");
   // A slot stands four cycles, so a change never follows within three
   slot_hold_a: assert property ($changed(lane_pos) |=> $stable(lane_pos) [*3])
      else $error("slot too short");
   // Unused slots carry a fixed low level in both orders
   spare_two_a: assert property ($fell(link_clock_pos) |-> !lane_pos[2] [*8])
      else $error("lane 2 spare slot not low");
   spare_three_a: assert property ($fell(link_clock_pos) |-> ##8 !lane_pos[3] [*4])
      else $error("lane 3 spare slot not low");

   // Main scenarios reached
   cover property ($rose(link_clock_pos));
   cover property ($fell(bit_map_select));
   cover property (link_clock_pos && lane_pos[0]);
endmodule

// >>> bench/lvds_panel_video_input_test.sv
// Purpose: both link ends joined, pixels sent and compared
// Assumes: shortened geometry, 8 pixels, 4 lines, 12 clocks a line
// Notes:   VESA then JEIDA order, supply raised once only
module lvds_panel_video_input_test
   import lvp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic               clk_i       = 1'b0;  // System clock
   logic               resetn_i    = 1'b0;  // Active low reset
   logic               supply_on_i = 1'b0;  // Module supply
   logic               video_en_i  = 1'b0;  // Video request
   logic               jeida_i     = 1'b0;  // Order select
   logic [COLOR_W-1:0] red_i, green_i, blue_i;
   logic [COLOR_W-1:0] red_o, green_o, blue_o;
   logic               pix_ack_o, backlight_on_o, pix_valid_o;
   logic               frame_start_o, line_start_o;
   logic               line_len_err_o, frame_len_err_o;
   logic [X_W-1:0]     pix_x_o, exp_x;     // Pixel index, seen and due
   logic [Y_W-1:0]     line_y_o, exp_y;    // Line index, seen and due
   logic [7:0]         pix_n = 8'h00;      // Next pixel number
   logic [31:0]        exp_q [$];          // Index and pixel taken, not yet seen
   logic [31:0]        exp_w;              // Entry due at the panel now
   int                 n_frame = 0;        // Frames seen at panel
   int                 checks = 0;
   int                 n_mismatch = 0;

   // Shortened geometry shared by both ends
   localparam int TB_H_ACT = 8;   // Enabled clocks per line
   localparam int TB_H_TOT = 12;  // Clocks per line
   localparam int TB_V_ACT = 4;   // Enabled lines per frame
   localparam int TB_V_TOT = 7;   // Lines per frame
   localparam int TB_GAP   = 12;  // Above line blank, below frame blank

   lvp_link_if lnk ();
   lvp_host_tx #(.H_ACT(TB_H_ACT), .H_TOT(TB_H_TOT), .V_ACT(TB_V_ACT), .V_TOT(TB_V_TOT))
   lvp_host_tx_i (
      .clk_i(clk_i), .resetn_i(resetn_i), .link(lnk), .supply_on_i(supply_on_i),
      .video_en_i(video_en_i), .jeida_i(jeida_i), .red_i(red_i), .green_i(green_i),
      .blue_i(blue_i), .pix_ack_o(pix_ack_o), .backlight_on_o(backlight_on_o));
   lvp_panel_rx #(.ACTIVE_PIX(TB_H_ACT), .ACTIVE_LINES(TB_V_ACT), .GAP_LIMIT(TB_GAP))
   lvp_panel_rx_i (
      .clk_i(clk_i), .resetn_i(resetn_i), .link(lnk), .red_o(red_o), .green_o(green_o),
      .blue_o(blue_o), .pix_valid_o(pix_valid_o), .frame_start_o(frame_start_o),
      .line_start_o(line_start_o), .pix_x_o(pix_x_o), .line_y_o(line_y_o),
      .line_len_err_o(line_len_err_o), .frame_len_err_o(frame_len_err_o));
   lvp_link_chk lvp_link_chk_i (
      .clk_i(clk_i), .resetn_i(resetn_i), .lane_pos(lnk.lane_pos), .lane_neg(lnk.lane_neg),
      .link_clock_pos(lnk.link_clock_pos), .link_clock_neg(lnk.link_clock_neg),
      .bit_map_select(lnk.bit_map_select));

   // Basic colours and odd levels that expose bit order, by turns in groups of eight
   function automatic logic [23:0] pix_of(input logic [7:0] i);
      if (i[3] == 1'b0)
         return {{8{i[2]}}, {8{i[1]}}, {8{i[0]}}};
      return {i * 8'h1d, ~i, i ^ 8'h5a};
   endfunction

   task automatic compare(input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Clock of 50 ns
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end

   // Next pixel presented once the host has taken the last one
   always @(negedge clk_i)
   begin
      if (pix_ack_o === 1'b1)
      begin
         exp_q.push_back({pix_n, red_i, green_i, blue_i});
         pix_n = pix_n + 8'h01;
      end
      {red_i, green_i, blue_i} = pix_of(pix_n);
   end

   // Panel output judged pixel by pixel; errors must never pulse
   always @(negedge clk_i)
   begin
      compare({line_len_err_o, frame_len_err_o}, 2'b00);
      if (pix_valid_o === 1'b1)
      begin
         // Runs hold whole frames, so the pixel number gives its place
         exp_w = exp_q.size() ? exp_q.pop_front() : 32'hx;
         exp_x = X_W'(exp_w[31:24] % TB_H_ACT);
         exp_y = Y_W'(exp_w[31:24] / TB_H_ACT % TB_V_ACT);
         n_frame = n_frame + int'(frame_start_o === 1'b1);
         compare({red_o, green_o, blue_o}, exp_w[23:0]);
         compare(pix_x_o, exp_x);
         compare(line_y_o, exp_y);
         compare({frame_start_o, line_start_o}, {exp_x == '0 && exp_y == '0, exp_x == '0});
      end
   end

   // Link quiet before supply, driven in full after
   task automatic t_supply();
      repeat (20) @(negedge clk_i);
      compare({lnk.lane_pos, lnk.lane_neg, lnk.link_clock_pos, lnk.link_clock_neg}, 10'h000);
      compare(lnk.bit_map_select, 1'b0);
      supply_on_i = 1'b1;
      repeat (10) @(negedge clk_i);
      compare(lnk.lane_neg ^ lnk.lane_pos, 4'hf);
      compare(lnk.link_clock_neg ^ lnk.link_clock_pos, 1'b1);
   endtask

   // Three frames in one order, then video stopped and drained
   task automatic t_video(input logic jeida);
      int n;
      n = n_frame;
      jeida_i = jeida;
      repeat (4) @(negedge clk_i); // Order settles before video starts
      video_en_i = 1'b1;
      for (int k = 0; k < 12000 && n_frame < n + 3; k++)
         @(negedge clk_i);
      compare(n_frame >= n + 3, 1'b1);
      compare(lnk.bit_map_select, !jeida);
      compare(backlight_on_o, 1'b1);
      video_en_i = 1'b0;
      repeat (6) @(negedge clk_i);
      compare(backlight_on_o, 1'b0);
      repeat (3000) @(negedge clk_i);
      compare(exp_q.size(), 0);
   endtask

   // Main sequence
   initial
   begin
      repeat (4) @(negedge clk_i);
      resetn_i = 1'b1;
      t_supply();
      t_video(1'b0);
      t_video(1'b1);
      print_verdict();
   end

   // Hang guard, well past both video runs
   initial
   begin
      #2500000;
      n_mismatch++;
      print_verdict();
   end
endmodule
